//--- design/snsa_map.svh
`ifndef SNSA_MAP_SVH
`define SNSA_MAP_SVH

`define SNSA_ADDR_W      12
`define SNSA_OFF_INSTR   12'h000
`define SNSA_OFF_ACC     12'h004
`define SNSA_OFF_FLAGS   12'h008
`define SNSA_OFF_FADDR   12'h00C
`define SNSA_OFF_FDATA   12'h010

`define SNSA_OPC_SUB     6'h02
`define SNSA_OPC_SWAP    6'h0E
`define SNSA_INSTR_W     14
`define SNSA_OPC_MSB     13
`define SNSA_OPC_LSB     8
`define SNSA_DEST_BIT    7
`define SNSA_IDX_MSB     6

`define SNSA_FLAG_C      0
`define SNSA_FLAG_HC     1
`define SNSA_FLAG_Z      2
`define SNSA_FLAG_BUSY   3

`define SNSA_RST_INSTR   14'h0000
`define SNSA_RST_ACC     8'h00
`define SNSA_RST_FADDR   7'h00
`define SNSA_RAM_DEPTH   128

`endif

//--- design/snsa_pkg.sv
package snsa_pkg;

  typedef enum logic [1:0] {
    SNSA_IDLE   = 2'h0,
    SNSA_READ   = 2'h1,
    SNSA_EXEC   = 2'h3,
    SNSA_SETTLE = 2'h2
  } snsa_state_t;

  typedef struct packed {
    logic [5:0] opcode;
    logic       toFile;
    logic [6:0] index;
  } snsa_instr_t;

  typedef struct packed {
    logic zero;
    logic halfCarry;
    logic carry;
  } snsa_flags_t;

endpackage : snsa_pkg

//--- design/snsa_file_ram.sv
`timescale 1ns/1ps
`include "snsa_map.svh"

module snsa_file_ram (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [6:0] addr,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);

  logic [7:0] cells [`SNSA_RAM_DEPTH];
  logic [7:0] next_rdata;

  // read-before-write: a write shows on rdata one cycle later
  always_comb begin
    next_rdata = cells[addr];
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
    if (we) begin
      cells[addr] <= wdata;
    end
  end

endmodule : snsa_file_ram

//--- design/snsa_alu_top.sv
`timescale 1ns/1ps
`include "snsa_map.svh"

// Summary of operation
// - subtract opcode computes register minus accumulator
// - subtract result to accumulator or register
// - subtract sets carry, half-carry, zero; carry=no borrow
// - swap opcode exchanges nibbles, flags untouched
// - swap result to accumulator or register

module snsa_alu_top (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`SNSA_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic      [31:0]              prdata,
  output logic                          pslverr
);

  snsa_pkg::snsa_state_t state;
  snsa_pkg::snsa_state_t next_state;
  snsa_pkg::snsa_instr_t instr;
  snsa_pkg::snsa_instr_t next_instr;
  snsa_pkg::snsa_flags_t flags;
  snsa_pkg::snsa_flags_t next_flags;
  logic [7:0]            acc;
  logic [7:0]            next_acc;
  logic [6:0]            fileAddr;
  logic [6:0]            next_fileAddr;
  logic                  next_pready;
  logic [31:0]           next_prdata;
  logic                  next_pslverr;

  logic [6:0]            memAddr;
  logic                  memWe;
  logic [7:0]            memWdata;
  logic [7:0]            memRdata;

  logic                  apbHit;
  logic                  isSub;
  logic                  isSwap;
  logic [8:0]            subWide;
  logic [4:0]            subLow;
  logic [7:0]            result;
  snsa_pkg::snsa_instr_t wrInstr;

  snsa_file_ram u_ram (
    .clk   (clk),
    .rst_b (rst_b),
    .addr  (memAddr),
    .we    (memWe),
    .wdata (memWdata),
    .rdata (memRdata)
  );

  // bus is stalled while an instruction is in flight so the ram port is free
  assign apbHit = psel && penable && !pready && (state == snsa_pkg::SNSA_IDLE);
  assign isSub  = (instr.opcode == `SNSA_OPC_SUB);
  assign isSwap = (instr.opcode == `SNSA_OPC_SWAP);
  assign wrInstr = snsa_pkg::snsa_instr_t'(pwdata[`SNSA_INSTR_W-1:0]);

  // datapath: f + ~w + 1, carry out is the inverted borrow
  always_comb begin
    subWide = {1'b0, memRdata} + {1'b0, ~acc} + 9'h001;
    subLow  = {1'b0, memRdata[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    if (isSub) begin
      result = subWide[7:0];
    end else begin
      result = {memRdata[3:0], memRdata[7:4]};
    end
  end

  // ram port: instruction operand while executing, software window otherwise
  always_comb begin
    memAddr  = fileAddr;
    memWe    = 1'b0;
    memWdata = pwdata[7:0];
    if (state == snsa_pkg::SNSA_READ || state == snsa_pkg::SNSA_EXEC) begin
      memAddr = instr.index;
    end
    if (state == snsa_pkg::SNSA_EXEC && instr.toFile) begin
      memWe    = 1'b1;
      memWdata = result;
    end else if (apbHit && pwrite && paddr == `SNSA_OFF_FDATA) begin
      memWe = 1'b1;
    end
  end

  // sequencer and architectural state
  always_comb begin
    next_state    = state;
    next_instr    = instr;
    next_acc      = acc;
    next_flags    = flags;
    next_fileAddr = fileAddr;
    case (state)
      snsa_pkg::SNSA_IDLE: begin
        if (apbHit && pwrite && paddr == `SNSA_OFF_INSTR) begin
          next_instr = wrInstr;
          // unknown opcodes are stored but never executed
          if (wrInstr.opcode == `SNSA_OPC_SUB || wrInstr.opcode == `SNSA_OPC_SWAP) begin
            next_state = snsa_pkg::SNSA_READ;
          end
        end
        if (apbHit && pwrite && paddr == `SNSA_OFF_ACC) begin
          next_acc = pwdata[7:0];
        end
        if (apbHit && pwrite && paddr == `SNSA_OFF_FLAGS) begin
          next_flags.carry     = pwdata[`SNSA_FLAG_C];
          next_flags.halfCarry = pwdata[`SNSA_FLAG_HC];
          next_flags.zero      = pwdata[`SNSA_FLAG_Z];
        end
        if (apbHit && pwrite && paddr == `SNSA_OFF_FADDR) begin
          next_fileAddr = pwdata[6:0];
        end
      end
      snsa_pkg::SNSA_READ: begin
        next_state = snsa_pkg::SNSA_EXEC;
      end
      snsa_pkg::SNSA_EXEC: begin
        if (!instr.toFile) begin
          next_acc = result;
        end
        if (isSub) begin
          next_flags.carry     = subWide[8];
          next_flags.halfCarry = subLow[4];
          next_flags.zero      = (subWide[7:0] == 8'h00);
        end
        // swap leaves flags as they are, needs no branch here
        next_state = snsa_pkg::SNSA_SETTLE;
      end
      snsa_pkg::SNSA_SETTLE: begin
        // one cycle for the ram to re-read the software window address
        next_state = snsa_pkg::SNSA_IDLE;
      end
      default: begin
        next_state = snsa_pkg::SNSA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state    <= snsa_pkg::SNSA_IDLE;
      instr    <= snsa_pkg::snsa_instr_t'(`SNSA_RST_INSTR);
      acc      <= `SNSA_RST_ACC;
      flags    <= '0;
      fileAddr <= `SNSA_RST_FADDR;
    end else begin
      state    <= next_state;
      instr    <= next_instr;
      acc      <= next_acc;
      flags    <= next_flags;
      fileAddr <= next_fileAddr;
    end
  end

  // apb answer: always one wait state, longer while busy
  always_comb begin
    next_pready  = apbHit;
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (apbHit && !pwrite) begin
      case (paddr)
        `SNSA_OFF_INSTR: next_prdata = {18'h00000, instr};
        `SNSA_OFF_ACC:   next_prdata = {24'h000000, acc};
        `SNSA_OFF_FLAGS: next_prdata = {29'h00000000, flags};
        `SNSA_OFF_FADDR: next_prdata = {25'h0000000, fileAddr};
        `SNSA_OFF_FDATA: next_prdata = {24'h000000, memRdata};
        default:         next_pslverr = 1'b1;
      endcase
    end else if (apbHit) begin
      case (paddr)
        `SNSA_OFF_INSTR, `SNSA_OFF_ACC, `SNSA_OFF_FLAGS,
        `SNSA_OFF_FADDR, `SNSA_OFF_FDATA: next_pslverr = 1'b0;
        default:                          next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule : snsa_alu_top

//--- bench/snsa_alu_monitor.sv
`timescale 1ns/1ps
module snsa_alu_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_bound: assert property (psel && penable && !pready |-> ##[1:4] pready)
    else $error("access not answered in time");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_data_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_err_valid: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without answer");
  a_flags_width: assert property (pready && !pwrite && paddr == 12'h008 |-> prdata[31:3] == 29'h0)
    else $error("flags word wider than three bits");
  a_acc_width: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata[31:8] == 24'h0)
    else $error("accumulator wider than a byte");
  a_err_decode: assert property (pready |-> pslverr == (paddr[11:5] != 7'h00 || paddr[1:0] != 2'h0 || paddr[4:2] > 3'h4))
    else $error("error flag does not match address decode");
endmodule : snsa_alu_monitor

bind snsa_alu_top snsa_alu_monitor u_snsa_alu_monitor (.clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .prdata, .pslverr);

//--- bench/snsa_alu_top_bench.sv
`timescale 1ns/1ps
module snsa_alu_top_bench;
  logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        e;
  int          fails = 0, tests_run = 0;

  snsa_alu_top u_snsa_alu_top (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  always #4 clk = ~clk;

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) fails++;
    // idle cycle keeps psel from being driven twice in one step
    @(posedge clk);
  endtask : apb

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  // file index 0x45 is loaded, then the instruction is issued
  task automatic exec(input logic [5:0] op, input logic [7:0] f, w, input logic dst, input logic [2:0] fl);
    apb(1'b1, 12'h00C, 32'h45);
    apb(1'b1, 12'h010, {24'h0, f});
    apb(1'b1, 12'h004, {24'h0, w});
    apb(1'b1, 12'h008, {29'h0, fl});
    apb(1'b1, 12'h000, {18'h0, op, dst, 7'h45});
  endtask : exec

  task automatic check3(input logic [7:0] acc, fil, input logic [2:0] fl);
    apb(1'b0, 12'h004, 32'h0); chk("acc", q, {24'h0, acc});
    apb(1'b0, 12'h010, 32'h0); chk("file", q, {24'h0, fil});
    apb(1'b0, 12'h008, 32'h0); chk("flags", q, {29'h0, fl});
  endtask : check3

  task automatic t_sub;
    logic [7:0] fv [4] = '{8'h03, 8'h02, 8'h01, 8'h10};
    logic [7:0] wv [4] = '{8'h02, 8'h02, 8'h02, 8'h01};
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      r = fv[i] - wv[i];
      exec(6'h02, fv[i], wv[i], i[0], 3'b000);
      check3(i[0] ? wv[i] : r, i[0] ? r : fv[i], {r == 8'h0, fv[i][3:0] >= wv[i][3:0], fv[i] >= wv[i]});
    end
  endtask : t_sub

  task automatic t_swap;
    for (int d = 0; d < 2; d++) begin
      exec(6'h0E, 8'hA5, 8'h33, d[0], 3'b101);
      check3(d[0] ? 8'h33 : 8'h5A, d[0] ? 8'h5A : 8'hA5, 3'b101);
    end
  endtask : t_swap

  task automatic t_err;
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", q, 32'h0);
    apb(1'b1, 12'h014, 32'hFF);
    chk("unmapped wr err", {31'h0, e}, 32'h1);
    // unknown opcode is stored in the instruction register but leaves acc, file and flags untouched
    exec(6'h3F, 8'h77, 8'h11, 1'b0, 3'b010);
    check3(8'h11, 8'h77, 3'b010);
    apb(1'b0, 12'h000, 32'h0); chk("instr", q, {18'h0, 6'h3F, 1'b0, 7'h45});
    chk("mapped err", {31'h0, e}, 32'h0);
    apb(1'b0, 12'h00C, 32'h0); chk("faddr", q, 32'h45);
  endtask : t_err

  // second instruction issued at once must see the first one's result
  task automatic t_chain;
    exec(6'h02, 8'h05, 8'h03, 1'b1, 3'b000);
    apb(1'b1, 12'h000, {18'h0, 6'h0E, 1'b0, 7'h45});
    check3(8'h20, 8'h02, 3'b011);
  endtask : t_chain

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_sub();
    t_swap();
    t_err();
    t_chain();
    results();
  end

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    results();
  end
endmodule : snsa_alu_top_bench
